// ==== hdl/overlay_commit_pkg.sv ====
`default_nettype none
package overlay_commit_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned COLOR_W = 24;
  localparam int unsigned POS_W = 12;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned MAX_LAYERS = 4;
  // register offsets
  localparam logic [7:0] VPC_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h0c;
  localparam logic [7:0] IRQ_EN_OFS = 8'h10;
  localparam logic [7:0] LAYER_BASE = 8'h20;
  localparam logic [7:0] LAYER_STRIDE = 8'h08;
  localparam logic [7:0] OVL_OFS = 8'h04;
  // field positions
  localparam int unsigned PORT_EN_BIT = 0;
  localparam int unsigned COMMIT_BIT = 5;
  localparam int unsigned LAYER_EN_BIT = 0;
  localparam int unsigned COLOR_LSB = 8;
  localparam int unsigned POSX_LSB = 6;
  localparam int unsigned POSY_LSB = 19;
  localparam int unsigned ST_LOSS_BIT = 0;
  localparam int unsigned ST_COMMIT_BIT = 1;
  localparam int unsigned ST_HAZARD_BIT = 2;
  localparam int unsigned IRQ_FRAME_BIT = 0;
  localparam int unsigned IRQ_LOSS_BIT = 1;
  localparam int unsigned IRQ_APPLY_BIT = 2;
  // reset values
  localparam logic [31:0] VPC_RST = 32'h0000_0000;
  localparam logic [31:0] LAYER_ATTR_RST = 32'h0000_0000;
  localparam logic [31:0] OVL_ATTR_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
  // frame timing and layer size counts, in pixel clocks and lines
  localparam int unsigned H_ACTIVE_DEF = 640;
  localparam int unsigned H_FRONT_DEF = 16;
  localparam int unsigned H_SYNC_DEF = 96;
  localparam int unsigned H_BACK_DEF = 48;
  localparam int unsigned V_ACTIVE_DEF = 480;
  localparam int unsigned V_FRONT_DEF = 10;
  localparam int unsigned V_SYNC_DEF = 2;
  localparam int unsigned V_BACK_DEF = 33;
  localparam int unsigned LAYER_W_DEF = 64;
  localparam int unsigned LAYER_H_DEF = 64;
endpackage
`default_nettype wire

// ==== hdl/video_timing_gen.sv ====
`default_nettype none
module video_timing_gen import overlay_commit_pkg::*; #(
  parameter int unsigned H_ACTIVE = H_ACTIVE_DEF,
  parameter int unsigned H_FRONT = H_FRONT_DEF,
  parameter int unsigned H_SYNC = H_SYNC_DEF,
  parameter int unsigned H_BACK = H_BACK_DEF,
  parameter int unsigned V_ACTIVE = V_ACTIVE_DEF,
  parameter int unsigned V_FRONT = V_FRONT_DEF,
  parameter int unsigned V_SYNC = V_SYNC_DEF,
  parameter int unsigned V_BACK = V_BACK_DEF
) (
  input wire logic clock_i,             // pixel clock
  input wire logic rstn_i,              // async reset, active low
  input wire logic run_i,               // counters run while high
  output logic [POS_W-1:0] x_o,         // pixel column
  output logic [POS_W-1:0] y_o,         // pixel line
  output logic de_o,                    // active video
  output logic hsync_o,                 // line sync, active high
  output logic vsync_o,                 // frame sync, active high
  output logic frame_edge_o             // pulse one cycle before first pixel
);
  localparam int unsigned H_TOTAL = H_ACTIVE + H_FRONT + H_SYNC + H_BACK;
  localparam int unsigned V_TOTAL = V_ACTIVE + V_FRONT + V_SYNC + V_BACK;
  localparam logic [POS_W-1:0] H_LAST = POS_W'(H_TOTAL - 1);
  localparam logic [POS_W-1:0] V_LAST = POS_W'(V_TOTAL - 1);
  localparam logic [POS_W-1:0] H_ACT = POS_W'(H_ACTIVE);
  localparam logic [POS_W-1:0] V_ACT = POS_W'(V_ACTIVE);
  localparam logic [POS_W-1:0] HS_BEG = POS_W'(H_ACTIVE + H_FRONT);
  localparam logic [POS_W-1:0] HS_END = POS_W'(H_ACTIVE + H_FRONT + H_SYNC);
  localparam logic [POS_W-1:0] VS_BEG = POS_W'(V_ACTIVE + V_FRONT);
  localparam logic [POS_W-1:0] VS_END = POS_W'(V_ACTIVE + V_FRONT + V_SYNC);

  if (H_TOTAL > (1 << POS_W) || V_TOTAL > (1 << POS_W) || H_ACTIVE == 0 || V_ACTIVE == 0)
  begin : g_bad_timing
    $error("frame timing does not fit the position counters");
  end

  logic [POS_W-1:0] h_q;
  logic [POS_W-1:0] v_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      h_q <= '0;
      v_q <= '0;
    end else if (!run_i) begin
      h_q <= '0;
      v_q <= '0;
    end else if (h_q == H_LAST) begin
      h_q <= '0;
      v_q <= (v_q == V_LAST) ? '0 : v_q + 1'b1;
    end else begin
      h_q <= h_q + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      x_o <= '0;
      y_o <= '0;
      de_o <= 1'b0;
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      frame_edge_o <= 1'b0;
    end else begin
      x_o <= h_q;
      y_o <= v_q;
      de_o <= run_i && (h_q < H_ACT) && (v_q < V_ACT);
      hsync_o <= run_i && (h_q >= HS_BEG) && (h_q < HS_END);
      vsync_o <= run_i && (v_q >= VS_BEG) && (v_q < VS_END);
      frame_edge_o <= run_i && (h_q == H_LAST) && (v_q == V_LAST);
    end
  end
endmodule
`default_nettype wire

// ==== hdl/layer_window.sv ====
`default_nettype none
module layer_window import overlay_commit_pkg::*; #(
  parameter int unsigned LAYER_W = LAYER_W_DEF,
  parameter int unsigned LAYER_H = LAYER_H_DEF
) (
  input wire logic [POS_W-1:0] x_i,     // current column
  input wire logic [POS_W-1:0] y_i,     // current line
  input wire logic [POS_W-1:0] posx_i,  // layer left edge
  input wire logic [POS_W-1:0] posy_i,  // layer top edge
  input wire logic enable_i,            // layer enabled
  output logic hit_o                    // pixel lies inside the layer
);
  localparam logic [POS_W:0] LW = (POS_W+1)'(LAYER_W);
  localparam logic [POS_W:0] LH = (POS_W+1)'(LAYER_H);
  logic [POS_W:0] dx;
  logic [POS_W:0] dy;
  // wide differences so a layer near the max position never wraps back on screen
  assign dx = {1'b0, x_i} - {1'b0, posx_i};
  assign dy = {1'b0, y_i} - {1'b0, posy_i};
  assign hit_o = enable_i && (x_i >= posx_i) && (y_i >= posy_i) && (dx < LW) && (dy < LH);
endmodule
`default_nettype wire

// ==== hdl/overlay_commit_sync.sv ====
// Functional notes
// - layer attribute bit 0 enables layer
// - control bit 5 requests commit at frame
// - disable and commit same frame: no loss
// - disable and commit straddling frame: one-frame loss
// - sync-loss frame drives all pixels zero
// - recover at frame after commit set
`default_nettype none
module overlay_commit_sync import overlay_commit_pkg::*; #(
  parameter int unsigned NUM_LAYERS = 2,
  parameter int unsigned H_ACTIVE = H_ACTIVE_DEF,
  parameter int unsigned H_FRONT = H_FRONT_DEF,
  parameter int unsigned H_SYNC = H_SYNC_DEF,
  parameter int unsigned H_BACK = H_BACK_DEF,
  parameter int unsigned V_ACTIVE = V_ACTIVE_DEF,
  parameter int unsigned V_FRONT = V_FRONT_DEF,
  parameter int unsigned V_SYNC = V_SYNC_DEF,
  parameter int unsigned V_BACK = V_BACK_DEF,
  parameter int unsigned LAYER_W = LAYER_W_DEF,
  parameter int unsigned LAYER_H = LAYER_H_DEF
) (
  input wire logic clock_i,              // pixel and bus clock
  input wire logic rstn_i,               // async reset, active low
  input wire logic [ADDR_W-1:0] addr_i,  // register byte address
  input wire logic [DATA_W-1:0] wdata_i, // write data
  input wire logic wr_i,                 // write strobe
  input wire logic rd_i,                 // read strobe
  output logic [DATA_W-1:0] rdata_o,     // read data, cycle after rd_i
  output logic [COLOR_W-1:0] pixel_o,    // blended pixel
  output logic de_o,                     // active video
  output logic hsync_o,                  // line sync
  output logic vsync_o,                  // frame sync
  output logic sync_lost_o,              // frame under sync loss
  output logic irq_o                     // level interrupt
);
  if (NUM_LAYERS < 1 || NUM_LAYERS > MAX_LAYERS) begin : g_bad_layers
    $error("NUM_LAYERS must be 1 to 4");
  end

  localparam logic [POS_W-1:0] H_ACT = POS_W'(H_ACTIVE);
  localparam logic [POS_W-1:0] V_ACT = POS_W'(V_ACTIVE);
  localparam int unsigned TOP_LAYER = NUM_LAYERS - 1;

  function automatic logic [ADDR_W-1:0] layer_addr(input int unsigned idx, input logic ovl);
    layer_addr = LAYER_BASE + ADDR_W'(idx) * LAYER_STRIDE + (ovl ? OVL_OFS : 8'h00);
  endfunction

  function automatic logic on_screen(input logic [31:0] attr, input logic [31:0] pos);
    on_screen = attr[LAYER_EN_BIT] && (pos[POSX_LSB +: POS_W] < H_ACT)
                && (pos[POSY_LSB +: POS_W] < V_ACT);
  endfunction

  logic [31:0] vpc_q;
  logic commit_q;
  logic sync_loss_q;
  logic [NUM_LAYERS-1:0] hazard_q;
  logic [31:0] pend_attr_q [NUM_LAYERS];
  logic [31:0] pend_pos_q [NUM_LAYERS];
  logic [31:0] act_attr_q [NUM_LAYERS];
  logic [31:0] act_pos_q [NUM_LAYERS];
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [DATA_W-1:0] rdata_q;
  logic [COLOR_W-1:0] pixel_q;
  logic de_q;
  logic hs_q;
  logic vs_q;
  logic irq_q;

  logic [POS_W-1:0] tx;
  logic [POS_W-1:0] ty;
  logic tde;
  logic ths;
  logic tvs;
  logic frame_edge;
  logic [NUM_LAYERS-1:0] hit;
  logic [COLOR_W-1:0] mix_color;
  logic [DATA_W-1:0] rd_mux;
  logic wr_commit;
  logic loss_start;
  logic [IRQ_W-1:0] irq_set;
  logic irq_raw;

  video_timing_gen #(
    .H_ACTIVE(H_ACTIVE),
    .H_FRONT(H_FRONT),
    .H_SYNC(H_SYNC),
    .H_BACK(H_BACK),
    .V_ACTIVE(V_ACTIVE),
    .V_FRONT(V_FRONT),
    .V_SYNC(V_SYNC),
    .V_BACK(V_BACK)
  ) u_timing (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .run_i(vpc_q[PORT_EN_BIT]),
    .x_o(tx),
    .y_o(ty),
    .de_o(tde),
    .hsync_o(ths),
    .vsync_o(tvs),
    .frame_edge_o(frame_edge)
  );

  for (genvar g = 0; g < NUM_LAYERS; g++) begin : g_win
    layer_window #(
      .LAYER_W(LAYER_W),
      .LAYER_H(LAYER_H)
    ) u_win (
      .x_i(tx),
      .y_i(ty),
      .posx_i(act_pos_q[g][POSX_LSB +: POS_W]),
      .posy_i(act_pos_q[g][POSY_LSB +: POS_W]),
      .enable_i(act_attr_q[g][LAYER_EN_BIT]),
      .hit_o(hit[g])
    );
  end

  assign wr_commit = wr_i && (addr_i == VPC_OFS) && wdata_i[COMMIT_BIT];
  assign loss_start = frame_edge && (|hazard_q) && !commit_q;

  // control register; commit bit self-clears when the frame edge applies it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vpc_q <= VPC_RST;
      commit_q <= 1'b0;
    end else begin
      if (wr_i && addr_i == VPC_OFS) begin
        vpc_q <= wdata_i & ~(32'h1 << COMMIT_BIT);
      end
      if (wr_commit) begin
        commit_q <= 1'b1;
      end else if (frame_edge) begin
        commit_q <= 1'b0;
      end
    end
  end

  // pending and active layer configuration
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_LAYERS; i++) begin
        pend_attr_q[i] <= LAYER_ATTR_RST;
        pend_pos_q[i] <= OVL_ATTR_RST;
        act_attr_q[i] <= LAYER_ATTR_RST;
        act_pos_q[i] <= OVL_ATTR_RST;
      end
    end else begin
      for (int i = 0; i < NUM_LAYERS; i++) begin
        if (wr_i && addr_i == layer_addr(i, 1'b0)) begin
          pend_attr_q[i] <= wdata_i;
        end
        if (wr_i && addr_i == layer_addr(i, 1'b1)) begin
          pend_pos_q[i] <= wdata_i;
        end
        if (frame_edge && commit_q) begin
          act_attr_q[i] <= pend_attr_q[i];
          act_pos_q[i] <= pend_pos_q[i];
        end
      end
    end
  end

  // a visible layer disabled without a commit in the same frame is a hazard
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hazard_q <= '0;
    end else begin
      for (int i = 0; i < NUM_LAYERS; i++) begin
        if (wr_commit) begin
          hazard_q[i] <= 1'b0;
        end else if (wr_i && addr_i == layer_addr(i, 1'b0) && !wdata_i[LAYER_EN_BIT]
                     && pend_attr_q[i][LAYER_EN_BIT] && on_screen(act_attr_q[i], act_pos_q[i]))
        begin
          hazard_q[i] <= 1'b1;
        end else if (frame_edge) begin
          hazard_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_loss_q <= 1'b0;
    end else if (frame_edge) begin
      if (commit_q) begin
        sync_loss_q <= 1'b0;
      end else if (|hazard_q) begin
        sync_loss_q <= 1'b1;
      end
    end
  end

  always_comb begin
    mix_color = '0;
    for (int i = 0; i < NUM_LAYERS; i++) begin
      if (hit[i]) begin
        mix_color = act_attr_q[i][COLOR_LSB +: COLOR_W];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pixel_q <= '0;
      de_q <= 1'b0;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
    end else begin
      pixel_q <= (sync_loss_q || !tde) ? '0 : mix_color;
      de_q <= tde;
      hs_q <= ths;
      vs_q <= tvs;
    end
  end

  assign irq_set = {frame_edge && commit_q, loss_start, frame_edge};
  assign irq_raw = |(irq_st_q & irq_en_q);

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_st_q <= '0;
      irq_en_q <= IRQ_EN_RST;
      irq_q <= 1'b0;
    end else begin
      if (wr_i && addr_i == IRQ_CLR_OFS) begin
        irq_st_q <= (irq_st_q & ~wdata_i[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
      if (wr_i && addr_i == IRQ_EN_OFS) begin
        irq_en_q <= wdata_i[IRQ_W-1:0];
      end
      irq_q <= irq_raw;
    end
  end

  always_comb begin
    rd_mux = '0;
    case (addr_i)
      VPC_OFS: rd_mux = vpc_q | (32'(commit_q) << COMMIT_BIT);
      STAT_OFS: rd_mux = 32'({|hazard_q, commit_q, sync_loss_q});
      IRQ_STAT_OFS: rd_mux = 32'(irq_st_q);
      IRQ_EN_OFS: rd_mux = 32'(irq_en_q);
      default: begin
        for (int i = 0; i < NUM_LAYERS; i++) begin
          if (addr_i == layer_addr(i, 1'b0)) begin
            rd_mux = pend_attr_q[i];
          end
          if (addr_i == layer_addr(i, 1'b1)) begin
            rd_mux = pend_pos_q[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_i ? rd_mux : '0;
    end
  end

  assign rdata_o = rdata_q;
  assign pixel_o = pixel_q;
  assign de_o = de_q;
  assign hsync_o = hs_q;
  assign vsync_o = vs_q;
  assign sync_lost_o = sync_loss_q;
  assign irq_o = irq_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  chk_enable_gates_hit: assert property (!act_attr_q[0][LAYER_EN_BIT] |-> !hit[0])
    else $error("disabled layer produced a hit");
  chk_commit_request: assert property (wr_commit |=> commit_q && !vpc_q[COMMIT_BIT])
    else $error("commit write not recorded");
  chk_same_frame_ok: assert property (frame_edge && hazard_q == '0 && !sync_loss_q |=> !sync_loss_q)
    else $error("sync loss without a straddling disable");
  chk_straddle_loss: assert property (loss_start |=> sync_loss_q && irq_st_q[IRQ_LOSS_BIT])
    else $error("straddling disable did not raise sync loss");
  chk_blank_pixels: assert property (sync_loss_q && $stable(sync_loss_q) |=> pixel_o == '0)
    else $error("pixel not zero during sync loss");
  chk_recover_commit: assert property (frame_edge && commit_q |=> !sync_loss_q ##1 !sync_loss_q)
    else $error("no recovery after commit");
  chk_offscreen_safe: assert property (wr_i && addr_i == layer_addr(0, 1'b0) && !wr_commit
      && !on_screen(act_attr_q[0], act_pos_q[0]) && !hazard_q[0] |=> !hazard_q[0])
    else $error("offscreen layer raised a hazard");
  chk_offscreen_nohit: assert property (act_pos_q[TOP_LAYER][POSX_LSB +: POS_W] >= H_ACT
      |-> !hit[TOP_LAYER] || !tde)
    else $error("offscreen layer contributed pixels");
  chk_irq_level: assert property (irq_o == $past(irq_raw))
    else $error("interrupt level mismatch");
  chk_unmapped_read: assert property (rd_i && addr_i == 8'hfc |=> rdata_o == '0)
    else $error("unmapped read not zero");

  cov_straddle: cover property (loss_start ##[1:1000] frame_edge && commit_q);
  cov_same_frame: cover property (|hazard_q && wr_commit);
  cov_recovery: cover property (sync_loss_q ##1 !sync_loss_q);
endmodule
`default_nettype wire

// ==== bench/display_sink.sv ====
`default_nettype none
module display_sink import overlay_commit_pkg::*; (
  input wire logic clock_i,                // pixel clock
  input wire logic rstn_i,                 // async reset, active low
  input wire logic [COLOR_W-1:0] pixel_i,  // pixel from video port
  input wire logic de_i,                   // active video
  input wire logic hsync_i,                // line sync
  input wire logic vsync_i,                // frame sync
  output logic [15:0] frames_o,            // frames closed so far
  output logic [15:0] lit_o,               // nonzero pixels in last frame
  output logic [15:0] active_o,            // active pixels in last frame
  output logic [15:0] lines_o              // line syncs in last frame
);
  timeunit 1ns;
  timeprecision 1ns;
  logic vs_q;
  logic hs_q;
  logic [15:0] lit_q;
  logic [15:0] act_q;
  logic [15:0] ln_q;
  // a frame closes at each rising edge of vsync
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vs_q <= 1'b0;
      hs_q <= 1'b0;
      lit_q <= 16'h0;
      act_q <= 16'h0;
      ln_q <= 16'h0;
      frames_o <= 16'h0;
      lit_o <= 16'h0;
      active_o <= 16'h0;
      lines_o <= 16'h0;
    end else begin
      vs_q <= vsync_i;
      hs_q <= hsync_i;
      if (vsync_i && !vs_q) begin
        lines_o <= ln_q;
        ln_q <= 16'h0;
      end else if (hsync_i && !hs_q) begin
        ln_q <= ln_q + 16'h1;
      end
      if (vsync_i && !vs_q) begin
        frames_o <= frames_o + 16'h1;
        lit_o <= lit_q;
        active_o <= act_q;
        lit_q <= 16'h0;
        act_q <= 16'h0;
      end else if (de_i) begin
        act_q <= act_q + 16'h1;
        if (pixel_i != '0) begin
          lit_q <= lit_q + 16'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`default_nettype none
module tb_top import overlay_commit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // shortened frame: 8x4 active, default front porches and vertical sync
  localparam int H_TOT = 8 + H_FRONT_DEF + 1 + 1;
  localparam int V_TOT = 4 + V_FRONT_DEF + V_SYNC_DEF + 1;
  localparam int FRAME = H_TOT * V_TOT;
  localparam int CYC_LIMIT = 30 * FRAME;
  logic clock_i;
  logic rstn_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic [COLOR_W-1:0] pixel_o;
  logic de_o;
  logic hsync_o;
  logic vsync_o;
  logic sync_lost_o;
  logic irq_o;
  logic [15:0] frames;
  logic [15:0] lit;
  logic [15:0] active;
  logic [15:0] lines;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int loss_cyc = 0;

  overlay_commit_sync #(.H_ACTIVE(8), .H_SYNC(1), .H_BACK(1), .V_ACTIVE(4), .V_BACK(1)) i_dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pixel_o(pixel_o), .de_o(de_o), .hsync_o(hsync_o),
    .vsync_o(vsync_o), .sync_lost_o(sync_lost_o), .irq_o(irq_o));

  display_sink i_sink (.clock_i(clock_i), .rstn_i(rstn_i), .pixel_i(pixel_o), .de_i(de_o),
    .hsync_i(hsync_o), .vsync_i(vsync_o), .frames_o(frames), .lit_o(lit), .active_o(active),
    .lines_o(lines));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (sync_lost_o === 1'b1) loss_cyc++;
    if (cyc == CYC_LIMIT) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o & mask, exp);
  endtask

  // wait for n frames to close at the sink, just after vsync rises
  task automatic wait_frames(input int n);
    logic [15:0] f;
    int k;
    repeat (n) begin
      f = frames;
      k = 0;
      while (frames === f && k < 2 * FRAME) begin
        @(posedge clock_i);
        #1;
        k++;
      end
      if (k >= 2 * FRAME) n_fail++;
    end
  endtask

  initial begin
    rstn_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    // reset values and an unmapped place
    rd(8'h00, 32'hffffffff, 32'h0);
    rd(8'h20, 32'hffffffff, 32'h0);
    rd(8'h10, 32'hffffffff, 32'h0);
    rd(8'hfc, 32'hffffffff, 32'h0);
    $display("test reset done");
    // two visible layers, loss interrupt enabled only
    wr(8'h20, 32'habcdef01);
    wr(8'h24, 32'h0);
    wr(8'h28, 32'h12345601);
    wr(8'h2c, 32'h00100100);
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h21);
    rd(8'h00, 32'h20, 32'h20);
    wait_frames(3);
    rd(8'h00, 32'hffffffff, 32'h1);
    rd(8'h08, 32'h5, 32'h5);
    check(32'(lit), 32'd32);
    check(32'(irq_o), 32'h0);
    $display("test commit done");
    // disable and commit inside one frame
    loss_cyc = 0;
    wr(8'h20, 32'habcdef00);
    wr(8'h00, 32'h21);
    wait_frames(1);
    check(32'(lit), 32'd8);
    check(32'(active), 32'd32);
    check(32'(loss_cyc), 32'd0);
    check(32'(lines), 32'(V_TOT));
    $display("test same frame done");
    // re-enable, then disable in one frame and commit in the next
    wr(8'h20, 32'habcdef01);
    wr(8'h00, 32'h21);
    wait_frames(1);
    check(32'(lit), 32'd32);
    loss_cyc = 0;
    wr(8'h20, 32'habcdef00);
    rd(8'h04, 32'h4, 32'h4);
    wait_frames(1);
    check(32'(sync_lost_o), 32'h1);
    check(32'(lit), 32'd0);
    rd(8'h04, 32'h1, 32'h1);
    rd(8'h08, 32'h2, 32'h2);
    check(32'(irq_o), 32'h1);
    wr(8'h00, 32'h21);
    wait_frames(1);
    check(32'(sync_lost_o), 32'h0);
    check(32'(lit), 32'd8);
    check(32'(loss_cyc), 32'(FRAME));
    wr(8'h0c, 32'h2);
    repeat (2) @(posedge clock_i);
    #1;
    check(32'(irq_o), 32'h0);
    rd(8'h08, 32'h2, 32'h0);
    $display("test straddle done");
    // park the layer off screen first, then disable without commit
    wr(8'h2c, 32'h0003ffc0);
    wr(8'h00, 32'h21);
    wait_frames(1);
    rd(8'h2c, 32'hffffffff, 32'h0003ffc0);
    check(32'(lit), 32'd0);
    loss_cyc = 0;
    wr(8'h28, 32'h12345600);
    wait_frames(2);
    check(32'(loss_cyc), 32'd0);
    rd(8'h04, 32'h1, 32'h0);
    check(32'(active), 32'd32);
    $display("test parked layer done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
